// [bench/bmfifo_far.sv]
`timescale 1ns/1ns
module bmfifo_far (
  output logic             write_clk,
  output logic             write_strobe,
  output logic [17:0]      write_data_in,
  output logic             read_clk,
  output logic             read_strobe,
  input  wire logic [17:0] read_data_out
);
  int wcnt = 0;
  initial begin
    {write_clk, write_strobe, read_clk, read_strobe} = 4'h0;
    write_data_in = 18'h0;
  end
  function automatic logic [17:0] pat(input int i);
    return {9'(i) ^ 9'h1a5, 9'(i)};
  endfunction
  // Edges fall between core clock edges; data held 290 ns past the edge for the sampler
  task automatic wr(input int n, input logic strb);
    repeat (n) begin
      write_data_in = pat(wcnt);
      wcnt++;
      #110 if (strb) write_strobe = 1'b1; else write_clk = 1'b1;
      #200 {write_clk, write_strobe} = 2'h0;
      #90;
    end
    write_data_in = ~write_data_in;
  endtask
  task automatic rd(input logic strb, output logic [17:0] q);
    #110 if (strb) read_strobe = 1'b1; else read_clk = 1'b1;
    #200 {read_clk, read_strobe} = 2'h0;
    #90 q = read_data_out;
  endtask
endmodule

// [bench/bmfifo_monitor.sv]
`timescale 1ns/1ns
module bmfifo_monitor (
  input wire logic                      core_clk,
  input wire logic                      rst_b,
  input wire logic                      master_reset_n,
  input wire logic                      partial_reset_n,
  input wire logic                      output_en_n,
  input wire logic [17:0]               read_data_oe_n,
  input wire bmfifo_pkg::bmfifo_flags_t flags,
  input wire logic                      empty_flag,
  input wire logic                      full_flag,
  input wire logic                      half_full_flag,
  input wire logic                      almost_empty_flag,
  input wire logic                      almost_full_flag
);
  import bmfifo_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  property p_flag_mirror;
    flags == {empty_flag, full_flag, half_full_flag, almost_empty_flag, almost_full_flag};
  endproperty
  a_flag_mirror: assert property (p_flag_mirror) else $error("flag struct and pins differ");
  property p_full_half;
    full_flag |-> half_full_flag;
  endproperty
  a_full_half: assert property (p_full_half) else $error("full without half full");
  property p_full_af;
    full_flag |-> almost_full_flag;
  endproperty
  a_full_af: assert property (p_full_af) else $error("full without almost full");
  property p_empty_ae;
    empty_flag |-> almost_empty_flag;
  endproperty
  a_empty_ae: assert property (p_empty_ae) else $error("empty without almost empty");
  // Six cycles covers the two-stage pin sampler plus the flag register
  property p_mreset;
    !master_reset_n [*6] |-> empty_flag && !full_flag && !half_full_flag;
  endproperty
  a_mreset: assert property (p_mreset) else $error("master reset left data");
  property p_preset;
    !partial_reset_n [*6] |-> empty_flag && !full_flag && !half_full_flag;
  endproperty
  a_preset: assert property (p_preset) else $error("partial reset left data");
  property p_oe_off;
    output_en_n [*4] |-> read_data_oe_n == 18'h3ffff;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("outputs driven while disabled");
  property p_oe_on;
    $fell(output_en_n) |-> ##[1:4] read_data_oe_n == 18'h0;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("outputs not driven when enabled");
endmodule
bind bmfifo_top bmfifo_monitor u_mon (.core_clk, .rst_b, .master_reset_n, .partial_reset_n, .output_en_n,
  .read_data_oe_n, .flags, .empty_flag, .full_flag, .half_full_flag, .almost_empty_flag, .almost_full_flag);

// [bench/bmfifo_top_bench.sv]
`timescale 1ns/1ns
`define BMF_CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin fail_count++; $display("MISMATCH %s exp %h got %h", nm, e, a); end end
module bmfifo_top_bench;
  import bmfifo_pkg::*;
  logic core_clk = 1'b0, rst_b = 1'b0, master_reset_n = 1'b1, partial_reset_n = 1'b1;
  logic input_width_sel = 1'b0, output_width_sel = 1'b0, async_write_sel = 1'b0, async_read_sel = 1'b0;
  logic first_word_fallthrough_mode = 1'b0, byte_order_sel = 1'b0;
  logic write_en_n = 1'b0, read_en_n = 1'b0, output_en_n = 1'b1;
  logic offset_load = 1'b0;
  logic [10:0] ae_off = 11'h007;
  logic write_clk, write_strobe, read_clk, read_strobe;
  logic [17:0] write_data_in, read_data_out, read_data_oe_n, q, qb;
  bmfifo_flags_t flags;
  logic empty_flag, full_flag, half_full_flag, almost_empty_flag, almost_full_flag;
  logic [8:0] bq[$];
  int n_tests = 0, fail_count = 0;
  bmfifo_top dut (.core_clk, .rst_b, .master_reset_n, .partial_reset_n, .input_width_sel, .output_width_sel,
    .async_write_sel, .async_read_sel, .first_word_fallthrough_mode, .byte_order_sel,
    .almost_empty_offset(ae_off), .almost_full_offset(11'h007), .offset_load, .write_clk, .write_strobe,
    .write_en_n, .write_data_in, .read_clk, .read_strobe, .read_en_n, .output_en_n, .read_data_out,
    .read_data_oe_n, .flags, .empty_flag, .full_flag, .half_full_flag, .almost_empty_flag, .almost_full_flag);
  bmfifo_far far (.write_clk, .write_strobe, .write_data_in, .read_clk, .read_strobe, .read_data_out);
  task automatic cfg(input logic [5:0] c);
    @(posedge core_clk);
    {first_word_fallthrough_mode, async_read_sel, async_write_sel, byte_order_sel, output_width_sel,
      input_width_sel} <= c;
    master_reset_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    master_reset_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    bq = {};
  endtask
  // Byte model; a refused write is sent but not entered
  task automatic put(input int n, input logic keep);
    logic [17:0] w;
    for (int k = 0; k < n; k++) begin
      w = far.pat(far.wcnt + k);
      if (keep && input_width_sel) bq.push_back(byte_order_sel ? w[17:9] : w[8:0]);
      if (keep) bq.push_back(input_width_sel && !byte_order_sel ? w[17:9] : w[8:0]);
    end
    far.wr(n, async_write_sel);
  endtask
  task automatic get(input int n);
    logic [17:0] e;
    repeat (n) begin
      far.rd(async_read_sel, q);
      e = {9'h0, bq.pop_front()};
      if (output_width_sel) e = byte_order_sel ? {e[8:0], bq.pop_front()} : {bq.pop_front(), e[8:0]};
      `BMF_CHK("read_data_out", e, q)
    end
  endtask
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial forever #25 core_clk = ~core_clk;
  initial begin
    #2000000;
    fail_count++;
    finish_test;
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    `BMF_CHK("read_data_oe_n", 18'h3ffff, read_data_oe_n)
    output_en_n <= 1'b0;
    // Every width pairing and byte order; strobe reads only with standard timing
    for (int i = 0; i < 8; i++) begin
      cfg({1'b0, i[2], i[0] ^ i[1], i[2:0]});
      qb = read_data_out;
      put(4, 1'b1);
      `BMF_CHK("data_before_read", qb, read_data_out)
      get(i[0] ? (i[1] ? 4 : 8) : (i[1] ? 2 : 4));
      `BMF_CHK("empty_flag", 1'b1, empty_flag)
    end
    `BMF_CHK("read_data_oe_n", 18'h0, read_data_oe_n)
    cfg(6'h03);
    ae_off <= 11'h200;
    offset_load <= 1'b1;
    repeat (4) @(posedge core_clk);
    offset_load <= 1'b0;
    write_en_n <= 1'b1;
    put(1, 1'b0);
    `BMF_CHK("empty_flag", 1'b1, empty_flag)
    @(posedge core_clk);
    write_en_n <= 1'b0;
    put(256, 1'b1);
    #200 `BMF_CHK("half_full_flag", 1'b0, half_full_flag)
    `BMF_CHK("almost_empty_flag", 1'b1, almost_empty_flag)
    put(1, 1'b1);
    #200 `BMF_CHK("half_full_flag", 1'b1, half_full_flag)
    `BMF_CHK("almost_empty_flag", 1'b0, almost_empty_flag)
    put(255, 1'b1);
    #200 `BMF_CHK("full_flag", 1'b1, full_flag)
    `BMF_CHK("almost_full_flag", 1'b1, almost_full_flag)
    put(1, 1'b0);
    get(512);
    `BMF_CHK("empty_flag", 1'b1, empty_flag)
    qb = read_data_out;
    far.rd(1'b0, q);
    `BMF_CHK("read_when_empty", qb, q)
    cfg(6'h23);
    read_en_n <= 1'b1;
    // Second pass shows fall-through mode survived the partial reset
    repeat (2) begin
      put(1, 1'b0);
      far.rd(1'b0, q);
      far.rd(1'b0, q);
      `BMF_CHK("fallthrough_word", far.pat(far.wcnt - 1), read_data_out)
      @(posedge core_clk);
      partial_reset_n <= 1'b0;
      repeat (6) @(posedge core_clk);
      partial_reset_n <= 1'b1;
      repeat (6) @(posedge core_clk);
      `BMF_CHK("empty_flag", 1'b1, empty_flag)
    end
    finish_test;
  end
endmodule

// [logic/bmfifo_map.svh]
`ifndef BMFIFO_MAP_SVH
`define BMFIFO_MAP_SVH
`define BMFIFO_AW        10
`define BMFIFO_DEPTH     11'h400
`define BMFIFO_HALF      11'h200
`define BMFIFO_AE_RST    11'h007
`define BMFIFO_AF_RST    11'h007
`define BMFIFO_FIRST_WORD_FALLTHROUGH_MODE_DLY  2'h3
`define BMFIFO_BYTE_W    9
`define BMFIFO_WORD_W    18
`define BMFIFO_SYNC_RST  12'hc98
`define BMFIFO_FLAG_RST  5'h12
`endif

// [logic/bmfifo_pkg.sv]
package bmfifo_pkg;
  typedef struct packed {
    logic       wide;
    logic       async;
  } bmfifo_port_cfg_t;
  typedef struct packed {
    logic empty;
    logic full;
    logic half;
    logic almost_empty;
    logic almost_full;
  } bmfifo_flags_t;
  typedef enum logic [1:0] {
    BMFIFO_OUT_IDLE,
    BMFIFO_OUT_WAIT,
    BMFIFO_OUT_HOLD
  } bmfifo_out_state_t;
endpackage

// [logic/bmfifo_top.sv]
// Summary of operation
// - Port widths latched from selects at master reset
// - Sync write: store word per clock with enable
// - Async write: store on strobe rising edge
// - Sync read: one read per clock with enable
// - Async read: one read per strobe rising edge
// - Any clock rates below half the core_clk rate, no fixed relationship
// - Simultaneous independent writes and reads
// - Standard mode: first word needs explicit read
// - Standard read moves next word to outputs
// - Fall-through: first word after three read edges
// - Master reset clears data and settings
// - Partial reset clears data, keeps settings
// - Output enable off floats data outputs
// - Empty, full and half-full flags
// - Programmable almost-empty and almost-full thresholds
// - All four 9/18 width pairings supported
// - Selectable byte order when packing
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ns
`include "bmfifo_map.svh"
module bmfifo_top (
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  input  wire logic                    master_reset_n,
  input  wire logic                    partial_reset_n,
  input  wire logic                    input_width_sel,
  input  wire logic                    output_width_sel,
  input  wire logic                    async_write_sel,
  input  wire logic                    async_read_sel,
  input  wire logic                    first_word_fallthrough_mode,
  input  wire logic                    byte_order_sel,
  input  wire logic [10:0]             almost_empty_offset,
  input  wire logic [10:0]             almost_full_offset,
  input  wire logic                    offset_load,
  input  wire logic                    write_clk,
  input  wire logic                    write_strobe,
  input  wire logic                    write_en_n,
  input  wire logic [17:0]             write_data_in,
  input  wire logic                    read_clk,
  input  wire logic                    read_strobe,
  input  wire logic                    read_en_n,
  input  wire logic                    output_en_n,
  output logic [17:0]                  read_data_out,
  output logic [17:0]                  read_data_oe_n,
  output bmfifo_pkg::bmfifo_flags_t    flags,
  output logic                         empty_flag,
  output logic                         full_flag,
  output logic                         half_full_flag,
  output logic                         almost_empty_flag,
  output logic                         almost_full_flag
);
  import bmfifo_pkg::*;

  // All pins arrive from outside this clock domain
  logic [11:0] sync1_reg;
  logic [11:0] sync2_reg;
  logic [17:0] din1_reg;
  logic [17:0] din2_reg;
  logic [11:0] sync_in;
  assign sync_in = {master_reset_n, partial_reset_n, write_clk, write_strobe, write_en_n,
                    read_clk, read_strobe, read_en_n, output_en_n, input_width_sel,
                    output_width_sel, offset_load};
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      // Idle pin levels, so the edge detector sees no edge at reset release
      sync1_reg <= `BMFIFO_SYNC_RST;
      sync2_reg <= `BMFIFO_SYNC_RST;
      din1_reg  <= 18'h00000;
      din2_reg  <= 18'h00000;
    end else begin
      sync1_reg <= sync_in;
      sync2_reg <= sync1_reg;
      din1_reg  <= write_data_in;
      din2_reg  <= din1_reg;
    end
  end
  wire mrs_n_s = sync2_reg[11];
  wire prs_n_s = sync2_reg[10];
  wire wclk_s  = sync2_reg[9];
  wire wstb_s  = sync2_reg[8];
  wire wen_n_s = sync2_reg[7];
  wire rclk_s  = sync2_reg[6];
  wire rstb_s  = sync2_reg[5];
  wire ren_n_s = sync2_reg[4];
  wire oe_n_s  = sync2_reg[3];
  wire iw_s    = sync2_reg[2];
  wire ow_s    = sync2_reg[1];
  wire ldo_s   = sync2_reg[0];

  // Edge detection on the synchronised link clocks and strobes.
  // The previous-sample register resets to the idle level of each pin,
  // the same level the sampler resets to, so reset release makes no edge.
  // Each link edge must stay high and low for more than one core cycle to be seen.
  logic [3:0] prev_reg;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_reg <= 4'h0;
    end else begin
      prev_reg <= {wclk_s, wstb_s, rclk_s, rstb_s};
    end
  end
  function automatic logic bmfifo_rise(input logic now_lvl, input logic was_lvl);
    bmfifo_rise = now_lvl & ~was_lvl;
  endfunction
  function automatic logic bmfifo_fall(input logic now_lvl, input logic was_lvl);
    bmfifo_fall = ~now_lvl & was_lvl;
  endfunction
  wire wclk_rise = bmfifo_rise(wclk_s, prev_reg[3]);
  wire wstb_rise = bmfifo_rise(wstb_s, prev_reg[2]);
  wire rclk_rise = bmfifo_rise(rclk_s, prev_reg[1]);
  wire rclk_fall = bmfifo_fall(rclk_s, prev_reg[1]);
  wire rstb_rise = bmfifo_rise(rstb_s, prev_reg[0]);

  // Configuration loaded while master reset is low, held once it rises
  bmfifo_port_cfg_t in_cfg_reg;
  bmfifo_port_cfg_t out_cfg_reg;
  logic             first_word_fallthrough_mode_reg;
  logic             big_end_reg;
  logic [10:0]      ae_off_reg;
  logic [10:0]      af_off_reg;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      in_cfg_reg  <= '0;
      out_cfg_reg <= '0;
      first_word_fallthrough_mode_reg    <= 1'b0;
      big_end_reg <= 1'b0;
      ae_off_reg  <= `BMFIFO_AE_RST;
      af_off_reg  <= `BMFIFO_AF_RST;
    end else if (!mrs_n_s) begin
      in_cfg_reg  <= '{wide: iw_s, async: async_write_sel};
      out_cfg_reg <= '{wide: ow_s, async: async_read_sel};
      // Async reads force standard mode so output enable owns the bus
      first_word_fallthrough_mode_reg    <= first_word_fallthrough_mode & ~async_read_sel;
      big_end_reg <= byte_order_sel;
      ae_off_reg  <= `BMFIFO_AE_RST;
      af_off_reg  <= `BMFIFO_AF_RST;
    // Partial reset does not reach this block, so settings survive it
    // Offsets are only taken while the load pin is seen high
    end else if (ldo_s) begin
      ae_off_reg  <= almost_empty_offset;
      af_off_reg  <= almost_full_offset;
    end
  end

  // Storage is in bytes so every width pairing shares one pointer pair.
  // Pointers wrap at the depth; the byte count tells full from empty,
  // which keeps the refusal checks exact for one- and two-byte words.
  logic [8:0]  mem [0:(1<<`BMFIFO_AW)-1];
  logic [`BMFIFO_AW-1:0] wptr_reg;
  logic [`BMFIFO_AW-1:0] rptr_reg;
  logic [10:0]           count_reg;
  wire clear_data = ~mrs_n_s | ~prs_n_s;

  // Sync mode needs enable low on a clock edge; async mode uses the strobe edge alone
  wire wr_req = in_cfg_reg.async ? wstb_rise : (wclk_rise & ~wen_n_s);
  wire rd_evt = out_cfg_reg.async ? rstb_rise : (rclk_rise & ~ren_n_s);

  function automatic logic [10:0] bmfifo_bytes(input logic wide);
    bmfifo_bytes = wide ? 11'h002 : 11'h001;
  endfunction
  wire [10:0] wr_bytes = bmfifo_bytes(in_cfg_reg.wide);
  wire [10:0] rd_bytes = bmfifo_bytes(out_cfg_reg.wide);

  // A word whose bytes do not all fit is refused whole
  wire wr_room = (`BMFIFO_DEPTH - count_reg) >= wr_bytes;
  wire rd_have = count_reg >= rd_bytes;
  logic out_valid_reg;
  logic [1:0] fall_cnt_reg;
  bmfifo_out_state_t ostate_reg;
  bmfifo_out_state_t ostate_next;
  wire first_word_fallthrough_mode_take = first_word_fallthrough_mode_reg & rd_have & (~out_valid_reg | rd_evt)
                   & (ostate_reg == BMFIFO_OUT_HOLD);
  wire std_take  = ~first_word_fallthrough_mode_reg & rd_evt & rd_have;
  wire do_write  = wr_req & wr_room & ~clear_data;
  wire do_read   = (std_take | first_word_fallthrough_mode_take) & ~clear_data;

  // Byte lanes: upper lane (bits 17..9) goes first when big-endian.
  // Data comes through the same two-stage sampler as the write clock,
  // so the lanes line up with the edge that stores them.
  wire [8:0] w_lo = din2_reg[8:0];
  wire [8:0] w_b0 = in_cfg_reg.wide ? (big_end_reg ? din2_reg[17:9] : w_lo) : w_lo;
  wire [8:0] w_b1 = big_end_reg ? w_lo : din2_reg[17:9];
  wire [`BMFIFO_AW-1:0] wptr_p1 = wptr_reg + 1'b1;
  wire [`BMFIFO_AW-1:0] rptr_p1 = rptr_reg + 1'b1;
  wire [8:0] r_b0 = mem[rptr_reg];
  wire [8:0] r_b1 = mem[rptr_p1];
  wire [17:0] rd_word = out_cfg_reg.wide ?
                        (big_end_reg ? {r_b0, r_b1} : {r_b1, r_b0}) :
                        {9'h000, r_b0};

  always_ff @(posedge core_clk) begin
    if (do_write) begin
      mem[wptr_reg] <= w_b0;
      if (in_cfg_reg.wide) mem[wptr_p1] <= w_b1;
    end
  end

  wire [10:0] wr_add = do_write ? wr_bytes : 11'h000;
  wire [10:0] rd_sub = do_read ? rd_bytes : 11'h000;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      count_reg <= 11'h000;
    end else if (clear_data) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      count_reg <= 11'h000;
    end else begin
      if (do_write) wptr_reg <= wptr_reg + wr_bytes[`BMFIFO_AW-1:0];
      if (do_read) rptr_reg <= rptr_reg + rd_bytes[`BMFIFO_AW-1:0];
      count_reg <= count_reg + wr_add - rd_sub;
    end
  end

  // Fall-through waits three read clock transitions once data is present
  wire rclk_edge = rclk_rise | rclk_fall;
  always_comb begin
    ostate_next = ostate_reg;
    unique case (ostate_reg)
      BMFIFO_OUT_IDLE: begin
        if (first_word_fallthrough_mode_reg & rd_have & ~out_valid_reg) ostate_next = BMFIFO_OUT_WAIT;
      end
      // The third transition ends the wait: rise, fall, rise
      BMFIFO_OUT_WAIT: begin
        if (rclk_edge & (fall_cnt_reg == `BMFIFO_FIRST_WORD_FALLTHROUGH_MODE_DLY - 2'h1)) ostate_next = BMFIFO_OUT_HOLD;
      end
      BMFIFO_OUT_HOLD: begin
        if (~rd_have & ~out_valid_reg) ostate_next = BMFIFO_OUT_IDLE;
      end
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ostate_reg   <= BMFIFO_OUT_IDLE;
      fall_cnt_reg <= 2'h0;
    end else if (clear_data) begin
      ostate_reg   <= BMFIFO_OUT_IDLE;
      fall_cnt_reg <= 2'h0;
    end else begin
      ostate_reg <= ostate_next;
      if (ostate_reg != BMFIFO_OUT_WAIT) fall_cnt_reg <= 2'h0;
      else if (rclk_edge) fall_cnt_reg <= fall_cnt_reg + 2'h1;
    end
  end

  // Output register; in fall-through a read with nothing behind drops valid.
  // In standard timing the word simply stands until the next accepted read,
  // so a read refused for lack of data leaves the outputs untouched.
  logic [17:0] dout_reg;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dout_reg      <= 18'h00000;
      out_valid_reg <= 1'b0;
    end else if (clear_data) begin
      dout_reg      <= 18'h00000;
      out_valid_reg <= 1'b0;
    end else if (do_read) begin
      dout_reg      <= rd_word;
      out_valid_reg <= 1'b1;
    end else if (first_word_fallthrough_mode_reg & rd_evt) begin
      out_valid_reg <= 1'b0;
    end
  end
  assign read_data_out  = dout_reg;
  assign read_data_oe_n = {18{oe_n_s}};

  // Flags are computed in bytes against the capacity seen by each port
  wire [10:0] used = count_reg;
  logic [4:0] flag_reg;
  wire empty_n = first_word_fallthrough_mode_reg ? ~out_valid_reg : ~rd_have;
  wire full_n  = ~wr_room;
  wire half_n  = used > `BMFIFO_HALF;
  wire ae_n    = used <= ae_off_reg;
  wire af_n    = used >= (`BMFIFO_DEPTH - af_off_reg);
  // Registered so the flag pins never glitch while the count moves
  // Reset shows an empty buffer, which is also almost empty
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_reg <= `BMFIFO_FLAG_RST;
    end else begin
      flag_reg <= {empty_n, full_n, half_n, ae_n, af_n};
    end
  end
  assign flags = '{
    empty:        flag_reg[4],
    full:         flag_reg[3],
    half:         flag_reg[2],
    almost_empty: flag_reg[1],
    almost_full:  flag_reg[0]
  };
  assign empty_flag        = flag_reg[4];
  assign full_flag         = flag_reg[3];
  assign half_full_flag    = flag_reg[2];
  assign almost_empty_flag = flag_reg[1];
  assign almost_full_flag  = flag_reg[0];
  // Clock rates are free: only edges seen by core_clk matter, each below 10 MHz
  // A stopped link clock simply produces no edges and holds its port still
endmodule
